// ==== logic/wdg_pkg.sv ====
// constants, types and helpers shared by the windowed watchdog block
//============================================================
package wdg_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] WDG_IDX_CONTROL = 8'h00;
	localparam logic [7:0] WDG_IDX_STATUS = 8'h01;
	localparam int WDG_AW = 8;
	localparam logic [7:0] WDG_ADDR_CONTROL = {WDG_IDX_CONTROL[5:0], 2'b00};
	localparam logic [7:0] WDG_ADDR_STATUS = {WDG_IDX_STATUS[5:0], 2'b00};
	// field positions
	localparam int WDG_WIN_LSB = 4;
	localparam int WDG_PER_LSB = 0;
	localparam int WDG_LOCK_BIT = 7;
	localparam int WDG_BUSY_BIT = 0;
	// reset values
	localparam logic [7:0] WDG_CONTROL_RESET = 8'h00;
	localparam logic [7:0] WDG_STATUS_RESET = 8'h00;
	// highest legal period or window code
	localparam logic [3:0] WDG_CODE_MAX = 4'hb;
	// code 1 means 8 ticks, so the shift is code plus this
	localparam int WDG_CODE_SHIFT = 2;
	localparam int WDG_CNT_W = 14;
	// slow ticks a value or restart needs to cross domains
	localparam logic [1:0] WDG_SYNC_TICKS = 2'd2;

	typedef enum logic [1:0] {
		WDG_OFF,
		WDG_FIRST,
		WDG_CLOSED,
		WDG_OPEN
	} wdg_state_t;

	// tick count for a code; off and reserved codes give zero
	function automatic logic [WDG_CNT_W-1:0] wdg_ticks(input logic [3:0] code);
		logic [WDG_CNT_W-1:0] t;
		t = '0;
		if (code != 4'h0 && code <= WDG_CODE_MAX)
			t = WDG_CNT_W'(1) << (code + 4'(WDG_CODE_SHIFT));
		return t;
	endfunction
endpackage

// ==== logic/wdg_regs_top.sv ====
// windowed watchdog: apb registers, lock, crossing and window counter
//
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module wdg_regs_top
(
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic [wdg_pkg::WDG_AW-1:0] i_paddr,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_change_protection_gate,
	input wire logic i_debug_mode,
	input wire logic i_boot_done,
	input wire logic [7:0] i_boot_fuse_config,
	input wire logic i_dog_restart_instruction,
	input wire logic i_slow_count_clock,
	output logic o_sys_reset
);
	import wdg_pkg::*;

	//============================================================
	// reset release
	// async assert, release through two flops so every flop leaves reset
	// on the same edge
	logic rst_meta_r, rst_n;
	always_ff @(posedge i_core_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rst_meta_r <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n <= rst_meta_r;
		end
	end

	//============================================================
	// slow clock sampling
	// the slow clock is a pin, so two flops first; its rising edge
	// becomes a one-cycle tick
	logic sc_meta_r, sc_sync_r, sc_prev_r;
	logic tick;
	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sc_meta_r <= 1'b0;
			sc_sync_r <= 1'b0;
			sc_prev_r <= 1'b0;
		end
		else
		begin
			sc_meta_r <= i_slow_count_clock;
			sc_sync_r <= sc_meta_r;
			sc_prev_r <= sc_sync_r;
		end
	end
	assign tick = sc_sync_r & ~sc_prev_r;

	//============================================================
	// apb decode
	logic wr_fire, rd_take, hit_ctrl, hit_stat, boot_load;
	logic ctrl_wr, cfg_start, cfg_busy, cfg_done;
	assign wr_fire = i_psel & i_penable & i_pwrite & o_pready;
	// answer is built one cycle into the access phase
	assign rd_take = i_psel & i_penable & ~o_pready;
	assign hit_ctrl = i_paddr == WDG_ADDR_CONTROL;
	assign hit_stat = i_paddr == WDG_ADDR_STATUS;

	//============================================================
	// register file
	logic [7:0] ctrl_r, ctrl_nxt;
	logic lock_r, lock_nxt;
	logic boot_seen_r, boot_seen_nxt;
	logic pready_nxt, pslverr_nxt;
	logic [31:0] prdata_nxt;

	// boot copies the fuse once, on the first cycle boot is seen done
	assign boot_load = i_boot_done & ~boot_seen_r;
	// protected, and frozen while locked
	assign ctrl_wr = wr_fire & hit_ctrl & i_change_protection_gate & ~lock_r;
	assign cfg_start = ctrl_wr | boot_load;

	always_comb
	begin
		ctrl_nxt = ctrl_r;
		lock_nxt = lock_r;
		boot_seen_nxt = boot_seen_r | i_boot_done;
		pready_nxt = rd_take;
		pslverr_nxt = 1'b0;
		prdata_nxt = 32'h0000_0000;
		// both fields update together; locked or unprotected writes drop
		if (ctrl_wr)
			ctrl_nxt = i_pwdata[7:0];
		if (boot_load)
			ctrl_nxt = i_boot_fuse_config;
		// clear only in debug; a set or boot lock beats the clear
		if (wr_fire && hit_stat && i_change_protection_gate)
		begin
			if (!i_pwdata[WDG_LOCK_BIT] && i_debug_mode)
				lock_nxt = 1'b0;
			if (i_pwdata[WDG_LOCK_BIT])
				lock_nxt = 1'b1;
		end
		if (boot_load && i_boot_fuse_config[3:0] != 4'h0)
			lock_nxt = 1'b1;
		// read data and error ride along with pready
		if (rd_take)
		begin
			if (hit_ctrl)
				prdata_nxt = {24'h00_0000, ctrl_r};
			else if (hit_stat)
			begin
				prdata_nxt[WDG_LOCK_BIT] = lock_r;
				prdata_nxt[WDG_BUSY_BIT] = cfg_busy;
			end
			else
				pslverr_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r <= WDG_CONTROL_RESET;
			lock_r <= WDG_STATUS_RESET[WDG_LOCK_BIT];
			boot_seen_r <= 1'b0;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			lock_r <= lock_nxt;
			boot_seen_r <= boot_seen_nxt;
			o_pready <= pready_nxt;
			o_pslverr <= pslverr_nxt;
			o_prdata <= prdata_nxt;
		end
	end

	//============================================================
	// domain crossing of control and restart
	// busy is the crossing itself; a second write mid-flight is not
	// restarted, software must wait for busy low
	logic rs_start, rs_busy, rs_done;
	wdg_xfer u_cfg_xfer (
		.i_clk(i_core_clk),
		.i_rst_n(rst_n),
		.i_start(cfg_start),
		.i_tick(tick),
		.o_busy(cfg_busy),
		.o_done(cfg_done)
	);

	assign rs_start = i_dog_restart_instruction & ~i_debug_mode;
	wdg_xfer u_rs_xfer (
		.i_clk(i_core_clk),
		.i_rst_n(rst_n),
		.i_start(rs_start),
		.i_tick(tick),
		.o_busy(rs_busy),
		.o_done(rs_done)
	);

	//============================================================
	// window counter
	logic [7:0] act_r, act_nxt;
	logic [WDG_CNT_W-1:0] cnt_r, cnt_nxt, per_t, win_t;
	logic [WDG_CNT_W-1:0] new_per_t;
	wdg_state_t state_r, state_nxt;
	logic bite_nxt;

	assign per_t = wdg_ticks(act_r[WDG_PER_LSB +: 4]);
	assign win_t = wdg_ticks(act_r[WDG_WIN_LSB +: 4]);
	assign new_per_t = wdg_ticks(ctrl_r[WDG_PER_LSB +: 4]);

	// first holds the open count until a restart opens the first closed
	// window, or open when the window code is zero; debug halt clears the count
	// and, unless off, returns here
	always_comb
	begin
		act_nxt = act_r;
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		bite_nxt = 1'b0;
		if (cfg_done)
		begin
			act_nxt = ctrl_r;
			cnt_nxt = '0;
			state_nxt = (new_per_t != '0) ? WDG_FIRST : WDG_OFF;
		end
		else if (i_debug_mode)
		begin
			cnt_nxt = '0;
			if (state_r != WDG_OFF)
				state_nxt = WDG_FIRST;
		end
		else
		begin
			unique case (state_r)
				WDG_OFF:
					cnt_nxt = '0;
				WDG_FIRST, WDG_OPEN:
					if (rs_done)
					begin
						cnt_nxt = '0;
						state_nxt = (win_t != '0) ? WDG_CLOSED : WDG_OPEN;
					end
					else if (tick)
					begin
						if (cnt_r == per_t - WDG_CNT_W'(1))
						begin
							bite_nxt = 1'b1;
							cnt_nxt = '0;
							state_nxt = WDG_FIRST;
						end
						else
							cnt_nxt = cnt_r + WDG_CNT_W'(1);
					end
				WDG_CLOSED:
					if (rs_done)
					begin
						bite_nxt = 1'b1;
						cnt_nxt = '0;
						state_nxt = WDG_FIRST;
					end
					else if (tick)
					begin
						if (cnt_r == win_t - WDG_CNT_W'(1))
						begin
							cnt_nxt = '0;
							state_nxt = WDG_OPEN;
						end
						else
							cnt_nxt = cnt_r + WDG_CNT_W'(1);
					end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			act_r <= WDG_CONTROL_RESET;
			state_r <= WDG_OFF;
			cnt_r <= '0;
			o_sys_reset <= 1'b0;
		end
		else
		begin
			act_r <= act_nxt;
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			o_sys_reset <= bite_nxt;
		end
	end

	//============================================================
	// checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!rst_n);

	property p_locked_ctrl;
		lock_r && wr_fire && hit_ctrl && !boot_load |=> ctrl_r == $past(ctrl_r);
	endproperty
	a_locked_ctrl: assert property (p_locked_ctrl) else $error("locked control changed");
	property p_lock_sticky;
		lock_r && !i_debug_mode |=> lock_r;
	endproperty
	a_lock_sticky: assert property (p_lock_sticky) else $error("lock cleared outside debug");
	property p_lock_gate;
		!lock_r && !boot_load && !(wr_fire && hit_stat && i_change_protection_gate) |=> !lock_r;
	endproperty
	a_lock_gate: assert property (p_lock_gate) else $error("lock set without protected write");
	property p_boot_lock;
		boot_load && i_boot_fuse_config[3:0] != 4'h0 |=> lock_r;
	endproperty
	a_boot_lock: assert property (p_boot_lock) else $error("boot did not lock");
	property p_busy_rise;
		cfg_start && !cfg_busy |=> cfg_busy;
	endproperty
	a_busy_rise: assert property (p_busy_rise) else $error("busy not raised on write");
	// the value applied is the one held when the crossing ended
	property p_busy_fall;
		$fell(cfg_busy) |-> cfg_done ##1 act_r == $past(ctrl_r);
	endproperty
	a_busy_fall: assert property (p_busy_fall) else $error("busy fell without transfer");
	property p_status_zero;
		rd_take && hit_stat |=> o_prdata[31:8] == 24'h00_0000 && o_prdata[6:1] == 6'h00;
	endproperty
	a_status_zero: assert property (p_status_zero) else $error("status reserved bits set");
	property p_early_bite;
		state_r == WDG_CLOSED && rs_done && !cfg_done && !i_debug_mode |=> o_sys_reset;
	endproperty
	a_early_bite: assert property (p_early_bite) else $error("early restart not reset");
	property p_late_bite;
		state_r == WDG_OPEN && tick && !rs_done && !cfg_done && !i_debug_mode &&
			cnt_r == per_t - WDG_CNT_W'(1) |=> o_sys_reset;
	endproperty
	a_late_bite: assert property (p_late_bite) else $error("time-out did not reset");

	property p_off_quiet;
		state_r == WDG_OFF |=> !o_sys_reset;
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("reset while disabled");

	sequence s_rs_take;
		rs_start && !rs_busy;
	endsequence
	sequence s_rs_again;
		rs_busy && rs_start && !tick;
	endsequence
	property p_rs_take;
		s_rs_take |=> rs_busy && !rs_done;
	endproperty
	a_rs_take: assert property (p_rs_take) else $error("restart not taken");
	// a pending restart neither ends nor starts over on a second request
	property p_rs_ignore;
		s_rs_again |=> rs_busy && !rs_done;
	endproperty
	a_rs_ignore: assert property (p_rs_ignore) else $error("restart slot misbehaved");
	property p_window_next;
		(state_r == WDG_OPEN || state_r == WDG_FIRST) && rs_done && win_t != '0 &&
			!cfg_done && !i_debug_mode |=> state_r == WDG_CLOSED && cnt_r == '0;
	endproperty
	a_window_next: assert property (p_window_next) else $error("closed window not entered");

endmodule // wdg_regs_top
`default_nettype wire

// ==== logic/wdg_xfer.sv ====
// one crossing slot: busy from a start until two slow ticks have passed
`timescale 1ns/10ps
`default_nettype none
module wdg_xfer
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_start,
	input wire logic i_tick,
	output logic o_busy,
	output logic o_done
);
	import wdg_pkg::*;

	logic busy_r, busy_nxt;
	logic done_r, done_nxt;
	logic [1:0] cnt_r, cnt_nxt;

	//============================================================
	// crossing state
	// a start while busy is dropped, so the slot never restarts mid-flight
	always_comb
	begin
		busy_nxt = busy_r;
		done_nxt = 1'b0;
		cnt_nxt = cnt_r;
		if (!busy_r)
		begin
			if (i_start)
			begin
				busy_nxt = 1'b1;
				cnt_nxt = 2'd0;
			end
		end
		else if (i_tick)
		begin
			if (cnt_r == WDG_SYNC_TICKS - 2'd1)
			begin
				busy_nxt = 1'b0;
				done_nxt = 1'b1;
			end
			else
				cnt_nxt = cnt_r + 2'd1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			cnt_r <= 2'd0;
		end
		else
		begin
			busy_r <= busy_nxt;
			done_r <= done_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	assign o_busy = busy_r;
	assign o_done = done_r;
endmodule // wdg_xfer
`default_nettype wire

// ==== test/wdg_regs_top_tb.sv ====
// self-checking bench for the windowed watchdog register block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
	begin \
		compares++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp); \
		end \
	end
module wdg_regs_top_tb;
	import wdg_pkg::*;
	// slow tick period chosen unrelated to the 40 ns core period
	localparam int TICK_NS = 426;
	localparam int TICK_CYC = 11;
	logic i_core_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [WDG_AW-1:0] i_paddr = '0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [31:0] i_pwdata = 32'h0000_0000;
	logic [31:0] o_prdata;
	logic o_pready;
	logic o_pslverr;
	logic i_change_protection_gate = 1'b0;
	logic i_debug_mode = 1'b0;
	logic i_boot_done = 1'b0;
	logic [7:0] i_boot_fuse_config = 8'h00;
	logic i_dog_restart_instruction = 1'b0;
	logic i_slow_count_clock = 1'b0;
	logic o_sys_reset;
	int bad_count = 0;
	int compares = 0;
	int hits;
	int first;

	wdg_regs_top DUT
	(
		.i_core_clk(i_core_clk),
		.i_arst_n(i_arst_n),
		.i_paddr(i_paddr),
		.i_psel(i_psel),
		.i_penable(i_penable),
		.i_pwrite(i_pwrite),
		.i_pwdata(i_pwdata),
		.o_prdata(o_prdata),
		.o_pready(o_pready),
		.o_pslverr(o_pslverr),
		.i_change_protection_gate(i_change_protection_gate),
		.i_debug_mode(i_debug_mode),
		.i_boot_done(i_boot_done),
		.i_boot_fuse_config(i_boot_fuse_config),
		.i_dog_restart_instruction(i_dog_restart_instruction),
		.i_slow_count_clock(i_slow_count_clock),
		.o_sys_reset(o_sys_reset)
	);

	//============================================================
	// clocks
	always #20 i_core_clk = ~i_core_clk;
	always #(TICK_NS / 2) i_slow_count_clock = ~i_slow_count_clock;

	//============================================================
	// bus and helper tasks
	// one apb transfer; request held until the edge that sees pready
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [7:0] wd, input logic prot,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(posedge i_core_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= {24'h00_0000, wd};
		i_change_protection_gate <= prot;
		@(posedge i_core_clk);
		i_penable <= 1'b1;
		// sampled values at the edge are what the block itself sees
		do
		begin
			@(posedge i_core_clk);
			n++;
		end
		while (o_pready !== 1'b1 && n < 50);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		i_change_protection_gate <= 1'b0;
		if (n >= 50)
			bad_count++;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic prot);
		logic [31:0] rd;
		logic err;
		apb(1'b1, a, d, prot, rd, err);
	endtask

	// read a register and compare data and error flag
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp,
		input logic experr);
		logic [31:0] rd;
		logic err;
		apb(1'b0, a, 8'h00, 1'b0, rd, err);
		`CHK(rd, {24'h00_0000, exp})
		`CHK(err, experr)
	endtask

	// poll status until the crossing is over, bounded
	task automatic wait_idle;
		logic [31:0] rd;
		logic err;
		int n;
		n = 0;
		do
		begin
			apb(1'b0, WDG_ADDR_STATUS, 8'h00, 1'b0, rd, err);
			n++;
		end
		while (rd[0] !== 1'b0 && n < 40);
		`CHK(rd[0], 1'b0)
	endtask

	task automatic kick;
		@(posedge i_core_clk);
		i_dog_restart_instruction <= 1'b1;
		@(posedge i_core_clk);
		i_dog_restart_instruction <= 1'b0;
	endtask

	// count reset pulses over a span and note the first one
	task automatic watch(input int cyc);
		hits = 0;
		first = -1;
		for (int i = 0; i < cyc; i++)
		begin
			@(negedge i_core_clk);
			// an unknown level counts as a pulse so it cannot slip by
			if (o_sys_reset !== 1'b0)
			begin
				if (first < 0)
					first = i;
				hits++;
			end
		end
	endtask

	task automatic give_verdict;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	//============================================================
	// scenarios
	// boot load sets lock; lock blocks control; only debug clears it
	task automatic s_boot;
		i_boot_fuse_config <= 8'h03;
		i_boot_done <= 1'b1;
		wait_idle();
		rchk(WDG_ADDR_STATUS, 8'h80, 1'b0);
		rchk(WDG_ADDR_CONTROL, 8'h03, 1'b0);
		wr(WDG_ADDR_CONTROL, 8'h15, 1'b1);
		rchk(WDG_ADDR_CONTROL, 8'h03, 1'b0);
		wr(WDG_ADDR_STATUS, 8'h00, 1'b1);
		rchk(WDG_ADDR_STATUS, 8'h80, 1'b0);
		i_debug_mode <= 1'b1;
		wr(WDG_ADDR_STATUS, 8'h00, 1'b1);
		rchk(WDG_ADDR_STATUS, 8'h00, 1'b0);
		wr(WDG_ADDR_CONTROL, 8'h00, 1'b1);
		wait_idle();
		rchk(WDG_ADDR_CONTROL, 8'h00, 1'b0);
		i_debug_mode <= 1'b0;
	endtask

	// unprotected lock write and a write to the busy bit change nothing
	task automatic s_protect;
		wr(WDG_ADDR_STATUS, 8'h80, 1'b0);
		rchk(WDG_ADDR_STATUS, 8'h00, 1'b0);
		wr(WDG_ADDR_STATUS, 8'h01, 1'b1);
		rchk(WDG_ADDR_STATUS, 8'h00, 1'b0);
		rchk(8'h08, 8'h00, 1'b1);
	endtask

	// normal mode: restarts keep it quiet, silence gives one reset
	task automatic s_normal;
		wr(WDG_ADDR_CONTROL, 8'h01, 1'b1);
		rchk(WDG_ADDR_STATUS, 8'h01, 1'b0);
		wait_idle();
		repeat (4)
		begin
			kick();
			watch(4 * TICK_CYC);
			`CHK(hits, 0)
		end
		kick();
		watch(14 * TICK_CYC);
		`CHK(hits, 1)
		`CHK(first * 40 >= 9 * TICK_NS && first * 40 <= 12 * TICK_NS, 1)
	endtask

	// window mode: double restart ignored, early restart resets
	task automatic s_window;
		wr(WDG_ADDR_CONTROL, 8'h21, 1'b1);
		rchk(WDG_ADDR_CONTROL, 8'h21, 1'b0);
		wait_idle();
		kick();
		repeat (2) @(posedge i_core_clk);
		kick();
		watch(6 * TICK_CYC);
		`CHK(hits, 0)
		kick();
		watch(6 * TICK_CYC);
		`CHK(hits, 1)
		kick();
		watch(20 * TICK_CYC);
		`CHK(hits, 0)
		kick();
		watch(10 * TICK_CYC);
		`CHK(hits, 0)
	endtask

	//============================================================
	// main sequence and watchdog
	initial
	begin
		repeat (10) @(posedge i_core_clk);
		i_arst_n <= 1'b1;
		repeat (3) @(posedge i_core_clk);
		rchk(WDG_ADDR_CONTROL, WDG_CONTROL_RESET, 1'b0);
		rchk(WDG_ADDR_STATUS, 8'h00, 1'b0);
		s_boot();
		s_protect();
		s_normal();
		s_window();
		give_verdict();
	end

	// the whole run needs about a thousand cycles
	initial
	begin
		repeat (20000) @(posedge i_core_clk);
		bad_count++;
		give_verdict();
	end
endmodule // wdg_regs_top_tb
`undef CHK
`default_nettype wire
